// ==== design/rcs_cfg.svh ====
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define RCS_CLK_NS        8
`define RCS_SYS_KHZ       4000
`define RCS_SYSDIV_CYC    (1000000 / `RCS_SYS_KHZ / `RCS_CLK_NS)
`define RCS_POR_HOLD_NS   18000000
`define RCS_POR_HOLD_CYC  ((`RCS_POR_HOLD_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
`define RCS_RST_HOLD_NS   10000
`define RCS_RST_HOLD_CYC  ((`RCS_RST_HOLD_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
// ----------------------------------------
// register indexes (byte address = 4 * index)
// ----------------------------------------
`define RCS_IDX_PCL       8'h02
`define RCS_IDX_STATUS    8'h03
`define RCS_IDX_TRIM      8'h05
`define RCS_IDX_CMP       8'h07
`define RCS_IDX_OPTION    8'h08
`define RCS_IDX_DIR       8'h09
`define RCS_IDX_CFG       8'h0a
// ----------------------------------------
// field positions
// ----------------------------------------
`define RCS_ST_PINW       7
`define RCS_ST_CMPW       6
`define RCS_ST_TO         4
`define RCS_ST_PD         3
`define RCS_CFG_RPS       4
`define RCS_CFG_CP        3
`define RCS_CFG_WDE       2
`define RCS_OPT_PWU_N     7
`define RCS_CMP_CWU_N     0
`define RCS_CFG_MASK      12'h01c
// ----------------------------------------
// reset values
// ----------------------------------------
`define RCS_PCL_RST       8'hff
`define RCS_PCL_WRAP      8'h00
`define RCS_STATUS_POR    8'h18
`define RCS_TRIM_RST      8'hfe
`define RCS_CMP_RST       8'hff
`define RCS_OPT_RST       8'hff
`define RCS_DIR_RST       4'hf
`endif

// ==== design/rcs_pkg.sv ====
package rcs_pkg;
   // sequencer states
   typedef enum logic [1:0] {
      RCS_ST_PWR  = 2'b00,
      RCS_ST_HOLD = 2'b01,
      RCS_ST_RUN  = 2'b10
   } rcs_state_e;
   // one data byte
   typedef logic [7:0] rcs_byte_t;
endpackage

// ==== design/rcs_top.sv ====
`timescale 1ns/1ps
`include "rcs_cfg.svh"
// Notes on behaviour
// R1: config word 12 bits, unused bits zero
// R2: bit 4 picks reset pin or plain input
// R3: bit 3 zero turns code protection on
// R4: only config bit 2 enables the watchdog
// R5: config word hidden while code runs
// R6: internal oscillator only, 4 MHz clock
// R7: start at last address, then wrap 0x000
// R8: calibration word always readable
// R9: trim at 05h, 0xfe on power-on only
// R10: working register takes calibration value
// R11: seven distinct reset causes
// R12: pin and watchdog resets in sleep keep most registers
// R13: timer and indirect data never reset
// R14: program counter low forced to 0xff
// R15: status values for power-on and pin reset
// R16: status values for watchdog resets
// R17: status values for wake-up resets
// R18: status holds four cause flags
// R19: sleep wakes on pin, comparator, watchdog
// R20: long start hold after power-up only
// R21: start timer counts once pin is high
// R22: flags update as reset asserts
module rcs_top #(
   parameter int unsigned POR_HOLD_CYC = `RCS_POR_HOLD_CYC
) (
   // clock and power-on reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write channels
   input  wire logic [11:0]       awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // axi4-lite read channels
   input  wire logic [11:0]       araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // configuration and calibration
   input  wire logic [11:0]       cfg_word,
   input  wire rcs_pkg::rcs_byte_t cal_word,
   input  wire logic              prog_read_last,
   output logic                   prog_read_allow,
   output logic                   code_protect,
   output logic                   watchdog_enable,
   output logic                   reset_pin_select,
   // reset and wake sources
   input  wire logic              shared_input_pin,
   input  wire logic              watchdog_timeout,
   input  wire logic              pin_change,
   input  wire logic              comparator_change,
   input  wire logic              comparator_out,
   input  wire logic              core_sleep,
   input  wire logic              sleep_enter,
   // core side
   output logic                   core_reset_n,
   output logic                   regs_clear,
   output logic                   sys_clk_en,
   output rcs_pkg::rcs_byte_t     working_value,
   output rcs_pkg::rcs_byte_t     program_counter_low,
   output rcs_pkg::rcs_byte_t     status_flags,
   output rcs_pkg::rcs_byte_t     osc_trim,
   output rcs_pkg::rcs_byte_t     comparator_control,
   output rcs_pkg::rcs_byte_t     option_control,
   output logic [3:0]             pin_direction
);
   import rcs_pkg::*;

   // ----------------------------------------
   // configuration decode
   // ----------------------------------------
   logic       ext_n_eff;   // reset pin level after select
   logic [11:0] cfg_view;   // config with unused bits zeroed

   assign cfg_view = cfg_word & `RCS_CFG_MASK;                  // R1
   assign reset_pin_select = cfg_word[`RCS_CFG_RPS];
   // io mode ties the reset input high inside
   assign ext_n_eff = reset_pin_select ? shared_input_pin : 1'b1; // R2
   assign code_protect = ~cfg_word[`RCS_CFG_CP];               // R3
   // no register can override this enable
   assign watchdog_enable = cfg_word[`RCS_CFG_WDE];            // R4
   // last word stays open so user code can fetch its trim
   assign prog_read_allow = ~code_protect | prog_read_last;     // R8

   // ----------------------------------------
   // reset sequencer
   // ----------------------------------------
   rcs_state_e  state;      // sequencer state
   rcs_state_e  next_state;
   logic [21:0] cnt;        // start-up timer count
   logic [21:0] next_cnt;
   logic [21:0] hold_last;  // last count of the current hold
   logic [4:0]  div;        // system clock divider
   logic [4:0]  next_div;
   logic        wrap;       // first fetch still pending
   logic        next_wrap;
   logic        in_run;
   logic        hold_done;
   logic        ev_ext, ev_wdt, ev_pin, ev_cmp, any_evt;

   assign in_run = (state == RCS_ST_RUN);
   assign core_reset_n = in_run;
   // long hold only out of power-up
   assign hold_last = (state == RCS_ST_PWR) ?
                      22'(POR_HOLD_CYC - 1) :
                      22'(`RCS_RST_HOLD_CYC - 1);              // R20
   assign hold_done = !in_run && ext_n_eff && (cnt == hold_last);
   // one tick per 4 MHz cycle; 125/4 is not whole, so rounded down
   assign sys_clk_en = (div == 5'(`RCS_SYSDIV_CYC - 1));       // R6

   // cause decode, one at a time by priority
   assign ev_ext = in_run && !ext_n_eff;                       // R11
   assign ev_wdt = in_run && !ev_ext && watchdog_timeout &&
                   watchdog_enable;                             // R4
   // wake sources only count while asleep
   assign ev_pin = in_run && !ev_ext && !ev_wdt && core_sleep &&
                   pin_change && !option_control[`RCS_OPT_PWU_N]; // R19
   assign ev_cmp = in_run && !ev_ext && !ev_wdt && !ev_pin &&
                   core_sleep && comparator_change &&
                   !comparator_control[`RCS_CMP_CWU_N];         // R19
   assign any_evt = ev_ext | ev_wdt | ev_pin | ev_cmp;

   // next state of the sequencer
   always_comb
   begin
      next_state = state;
      next_cnt   = cnt;
      next_wrap  = wrap;
      next_div   = sys_clk_en ? 5'h00 : div + 5'h01;
      unique case (state)
         RCS_ST_PWR, RCS_ST_HOLD:
         begin
            // timer waits for the pin to read high
            if (!ext_n_eff)
               next_cnt = '0;                                   // R21
            else if (hold_done)
            begin
               next_state = RCS_ST_RUN;
               next_cnt   = '0;
               next_wrap  = 1'b1;
            end
            else
               next_cnt = cnt + 22'h000001;
         end
         RCS_ST_RUN:
         begin
            if (any_evt)
            begin
               next_state = RCS_ST_HOLD;
               next_cnt   = '0;
               next_wrap  = 1'b0;
            end
            else if (sys_clk_en)
               next_wrap = 1'b0;
         end
         // unused code falls back to power-up
         default:
            next_state = RCS_ST_PWR;
      endcase
   end

   // sequencer flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= RCS_ST_PWR;
         cnt   <= '0;
         div   <= '0;
         wrap  <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt   <= next_cnt;
         div   <= next_div;
         wrap  <= next_wrap;
      end
   end

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic       wr_fire;     // write address and data taken
   logic       ar_fire;     // read address taken
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic       wr_top_ok;
   logic       rd_top_ok;

   assign wr_fire = awvalid && wvalid && !bvalid;
   assign awready = wr_fire;
   assign wready  = wr_fire;
   assign ar_fire = arvalid && !rvalid;
   assign arready = !rvalid;
   assign wr_idx  = awaddr[9:2];
   assign rd_idx  = araddr[9:2];
   assign wr_top_ok = (awaddr[11:10] == 2'b00) && (awaddr[1:0] == 2'b00);
   assign rd_top_ok = (araddr[11:10] == 2'b00) && (araddr[1:0] == 2'b00);

   // ----------------------------------------
   // architectural registers
   // ----------------------------------------
   rcs_byte_t  next_pcl, next_status, next_trim, next_cmp;
   rcs_byte_t  next_opt, next_w;
   logic [3:0] next_dir;
   logic       next_clear;
   logic       wr_lo;       // low byte lane written

   assign wr_lo = wr_fire && wr_top_ok && wstrb[0];

   // register updates; reset events come last so set wins
   always_comb
   begin
      next_pcl    = program_counter_low;
      next_status = status_flags;
      next_trim   = osc_trim;
      next_cmp    = {comparator_out, comparator_control[6:0]};
      next_opt    = option_control;
      next_dir    = pin_direction;
      next_w      = working_value;
      next_clear  = 1'b0;
      if (wr_lo)
      begin
         unique case (wr_idx)
            `RCS_IDX_PCL:
               if (in_run)
                  next_pcl = wdata[7:0];
            // cause bits 4:3 are read-only, bit 5 reads zero
            `RCS_IDX_STATUS:
               next_status = {wdata[7:6], 1'b0, status_flags[4:3],
                              wdata[2:0]};
            `RCS_IDX_TRIM:
               next_trim = wdata[7:0];                          // R9
            `RCS_IDX_CMP:
               next_cmp = {comparator_out, wdata[6:0]};
            `RCS_IDX_OPTION:
               next_opt = wdata[7:0];
            `RCS_IDX_DIR:
               next_dir = wdata[3:0];
            default:
               next_pcl = program_counter_low;
         endcase
      end
      // sleep entry clears power-down and sets time-out
      if (in_run && sleep_enter && !any_evt)
         next_status[`RCS_ST_TO:`RCS_ST_PD] = 2'b10;
      // first fetch after release rolls past the top
      if (in_run && wrap && sys_clk_en && !any_evt)
         next_pcl = `RCS_PCL_WRAP;                              // R7
      if (ev_ext)
      begin
         if (core_sleep)
            next_status[7:3] = 5'b00010;                        // R15
         else
            next_status[7:5] = 3'b000;                          // R15
      end
      if (ev_wdt)
      begin
         if (core_sleep)
            next_status[7:3] = 5'b00000;                        // R16
         else
            next_status[7:4] = 4'b0000;                         // R16
      end
      if (ev_pin)
         next_status[7:3] = 5'b10010;                           // R17
      if (ev_cmp)
         next_status[7:3] = 5'b01010;                           // R17
      // trim and comparator keep their values here
      if (any_evt)
      begin
         next_opt = `RCS_OPT_RST;
         next_dir = `RCS_DIR_RST;
         // timer and indirect data are never on this line
         next_clear = !(core_sleep && (ev_ext || ev_wdt));      // R12 R13
      end
      // counter parked at the top while held
      if (!in_run || any_evt)
         next_pcl = `RCS_PCL_RST;                               // R14
      // the top-of-memory literal lands in the working value
      if (hold_done)
         next_w = cal_word;                                     // R10
   end

   // register flops; power-on values under reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         program_counter_low <= `RCS_PCL_RST;
         status_flags        <= `RCS_STATUS_POR;                // R15
         osc_trim            <= `RCS_TRIM_RST;                  // R9
         comparator_control  <= `RCS_CMP_RST;
         option_control      <= `RCS_OPT_RST;
         pin_direction       <= `RCS_DIR_RST;
         working_value       <= 8'h00;
         regs_clear          <= 1'b1;
      end
      else
      begin
         program_counter_low <= next_pcl;
         status_flags        <= next_status;                    // R22
         osc_trim            <= next_trim;
         comparator_control  <= next_cmp;
         option_control      <= next_opt;
         pin_direction       <= next_dir;
         working_value       <= next_w;
         regs_clear          <= next_clear;
      end
   end

   // ----------------------------------------
   // bus responses
   // ----------------------------------------
   logic        next_bvalid, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic        wr_map;

   assign wr_map = wr_top_ok && (wr_idx == `RCS_IDX_PCL ||
                   wr_idx == `RCS_IDX_STATUS || wr_idx == `RCS_IDX_TRIM ||
                   wr_idx == `RCS_IDX_CMP || wr_idx == `RCS_IDX_OPTION ||
                   wr_idx == `RCS_IDX_DIR);

   // write answer, then read data and answer
   always_comb
   begin
      next_bvalid = bvalid && !bready;
      next_bresp  = bresp;
      next_rvalid = rvalid && !rready;
      next_rresp  = rresp;
      next_rdata  = rdata;
      if (wr_fire)
      begin
         next_bvalid = 1'b1;
         next_bresp  = wr_map ? 2'b00 : 2'b10;
      end
      if (ar_fire)
      begin
         next_rvalid = 1'b1;
         next_rresp  = 2'b00;
         next_rdata  = 32'h00000000;
         if (!rd_top_ok)
            next_rresp = 2'b10;
         else
         begin
            unique case (rd_idx)
               `RCS_IDX_PCL:
                  next_rdata = {24'h000000, program_counter_low};
               `RCS_IDX_STATUS:
                  next_rdata = {24'h000000, status_flags};      // R18
               `RCS_IDX_TRIM:
                  next_rdata = {24'h000000, osc_trim};
               `RCS_IDX_CMP:
                  next_rdata = {24'h000000, comparator_control};
               // write-only registers read as zero
               `RCS_IDX_OPTION, `RCS_IDX_DIR:
                  next_rdata = 32'h00000000;
               // only visible while the core is held
               `RCS_IDX_CFG:
                  if (in_run)
                     next_rresp = 2'b10;                        // R5
                  else
                     next_rdata = {20'h00000, cfg_view};        // R1
               default:
                  next_rresp = 2'b10;
            endcase
         end
      end
   end

   // response flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= 2'b00;
         rvalid <= 1'b0;
         rresp  <= 2'b00;
         rdata  <= 32'h00000000;
      end
      else
      begin
         bvalid <= next_bvalid;
         bresp  <= next_bresp;
         rvalid <= next_rvalid;
         rresp  <= next_rresp;
         rdata  <= next_rdata;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_cfg_bits;
      ar_fire && rd_top_ok && rd_idx == `RCS_IDX_CFG && !in_run
      |=> rdata[11:5] == 7'h00 && rdata[1:0] == 2'b00;
   endproperty
   a_cfg_bits: assert property (p_cfg_bits) // R1
      else $error("config readback shows unused bits");

   property p_cfg_hidden;
      ar_fire && rd_top_ok && rd_idx == `RCS_IDX_CFG && in_run
      |=> rresp == 2'b10 && rdata == 32'h00000000;
   endproperty
   a_cfg_hidden: assert property (p_cfg_hidden) // R5
      else $error("config word readable while running");

   property p_io_mode;
      in_run && !reset_pin_select && !watchdog_timeout && !core_sleep
      |=> core_reset_n;
   endproperty
   a_io_mode: assert property (p_io_mode) // R2
      else $error("pin in io mode caused a reset");

   property p_wdt;
      in_run && watchdog_timeout && watchdog_enable && ext_n_eff
      |=> !core_reset_n && !status_flags[`RCS_ST_TO];
   endproperty
   a_wdt: assert property (p_wdt) // R4
      else $error("watchdog time-out not honoured");

   property p_pcl_held;
      !core_reset_n |-> program_counter_low == 8'hff;
   endproperty
   a_pcl_held: assert property (p_pcl_held) // R14
      else $error("program counter low not forced");

   property p_trim_kept;
      in_run && any_evt && !(wr_lo && wr_idx == `RCS_IDX_TRIM)
      |=> osc_trim == $past(osc_trim);
   endproperty
   a_trim_kept: assert property (p_trim_kept) // R9
      else $error("trim changed by a non power-on reset");

   property p_ext_sleep;
      in_run && !ext_n_eff && core_sleep
      |=> status_flags[7:3] == 5'b00010 && !core_reset_n;
   endproperty
   a_ext_sleep: assert property (p_ext_sleep) // R15
      else $error("wrong status after pin reset in sleep");

   property p_pin_wake;
      ev_pin |=> status_flags[7:3] == 5'b10010 && regs_clear;
   endproperty
   a_pin_wake: assert property (p_pin_wake) // R17
      else $error("wrong status after pin-change wake");

   property p_timer_wait;
      !in_run && !ext_n_eff |=> cnt == 22'h000000 && !core_reset_n;
   endproperty
   a_timer_wait: assert property (p_timer_wait) // R21
      else $error("start-up timer ran with pin low");

   property p_release;
      $rose(core_reset_n) |-> working_value == $past(cal_word)
         ##[1:32] program_counter_low == 8'h00;
   endproperty
   a_release: assert property (p_release) // R7
      else $error("release did not load trim and wrap");
endmodule

// ==== testbench/rcs_far.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// far side: core sleep state, pin and wake sources
// ----------------------------------------
module rcs_far (
   // clock and script command
   input  wire logic       aclk,
   input  wire logic       go,
   input  wire logic [2:0] kind,
   input  wire logic       core_reset_n,
   // event lines into the block
   output logic            shared_input_pin,
   output logic            watchdog_timeout,
   output logic            pin_change,
   output logic            comparator_change,
   output logic            comparator_out,
   output logic            core_sleep,
   output logic            sleep_enter
);
   logic [2:0] k;    // latched event kind
   logic [1:0] step; // script: sleep, then event, then pin held low one more step for pin resets
   logic       slp;  // kinds 1,3,4,5 start from sleep
   assign slp = k[0] | k[2];
   initial
   begin
      {watchdog_timeout, pin_change, comparator_change} = 3'h0;
      {sleep_enter, core_sleep} = 2'h0;
      {comparator_out, shared_input_pin} = 2'h3;
      step = 2'h0;
      k = 3'h0;
   end
   // pin has a pull-up, so released means high; comparator wanders
   always @(posedge aclk)
   begin
      comparator_out <= ~comparator_out;
      {watchdog_timeout, pin_change, comparator_change} <= 3'h0;
      sleep_enter <= 1'b0;
      shared_input_pin <= 1'b1;
      if (!core_reset_n)
         core_sleep <= 1'b0;
      if (go)
      begin
         k <= kind;
         step <= 2'h2;
      end
      else if (step == 2'h2)
      begin
         sleep_enter <= slp;
         core_sleep <= slp;
         step <= 2'h1;
      end
      else if (step == 2'h1)
      begin
         shared_input_pin <= (k[2:1] != 2'h0);
         watchdog_timeout <= (k[2:1] == 2'h1);
         pin_change <= (k == 3'h4);
         comparator_change <= (k == 3'h5);
         // pin resets keep the pin low one more cycle into the hold
         step <= (k[2:1] == 2'h0) ? 2'h3 : 2'h0;
      end
      else if (step == 2'h3)
      begin
         shared_input_pin <= 1'b0;
         step <= 2'h0;
      end
   end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import rcs_pkg::*;
   // ----------------------------------------
   // wiring
   // ----------------------------------------
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
   logic        bready, arvalid, arready, rvalid, rready, go;
   logic [11:0] awaddr, araddr, cfg_word;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, pin_direction;
   logic [1:0]  bresp, rresp;
   logic [2:0]  kind;
   rcs_byte_t   cal_word, working_value, program_counter_low, trim;
   rcs_byte_t   status_flags, osc_trim, comparator_control, option_control;
   logic        prog_read_last, prog_read_allow, code_protect, sys_clk_en;
   logic        watchdog_enable, reset_pin_select, shared_input_pin;
   logic        watchdog_timeout, pin_change, comparator_change, core_sleep;
   logic        comparator_out, sleep_enter, core_reset_n, regs_clear;
   logic [33:0] expq[$]; // expected {rresp, rdata} in issue order
   rcs_byte_t   st_tab[6];
   logic [2:0]  k_tab[6];
   int          mismatches, checked;
   rcs_top #(.POR_HOLD_CYC(20)) i_dut (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .cfg_word, .cal_word, .prog_read_last, .prog_read_allow, .code_protect,
      .watchdog_enable, .reset_pin_select, .shared_input_pin,
      .watchdog_timeout, .pin_change, .comparator_change, .comparator_out,
      .core_sleep, .sleep_enter, .core_reset_n, .regs_clear, .sys_clk_en,
      .working_value, .program_counter_low, .status_flags, .osc_trim,
      .comparator_control, .option_control, .pin_direction);
   rcs_far i_far (.aclk, .go, .kind, .core_reset_n, .shared_input_pin,
      .watchdog_timeout, .pin_change, .comparator_change, .comparator_out,
      .core_sleep, .sleep_enter);
   // ----------------------------------------
   // compare, verdict and bus tasks
   // ----------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // write: both channels offered together, held until taken
   task automatic wr(input logic [11:0] a, input rcs_byte_t d,
                     input logic [1:0] er);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      check(bresp, er);
      // idle edge so a following call never re-raises bready here
      @(posedge aclk);
   endtask
   // read: the expected answer is noted before the request goes out
   task automatic rd(input logic [11:0] a, input logic [1:0] er,
                     input rcs_byte_t ed);
      expq.push_back({er, 24'h0, ed});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      // idle edge so a following call never re-raises rready here
      @(posedge aclk);
   endtask
   // bounded wait on the core hold line
   task automatic wait_core(input logic lvl);
      int n;
      n = 0;
      while (core_reset_n !== lvl && n < 3000)
      begin
         @(posedge aclk);
         n++;
      end
      check(core_reset_n, lvl);
   endtask
   // one reset event through the far-side model
   task automatic fire(input logic [2:0] k, input logic hit,
                       input rcs_byte_t st);
      kind <= k;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (6) @(posedge aclk);
      check(core_reset_n, !hit);
      if (hit)
      begin
         check(program_counter_low, 8'hff);
         check({option_control, pin_direction}, 12'hfff);
         wait_core(1'b1);
         check(working_value, cal_word);
         repeat (40) @(posedge aclk);
         check(program_counter_low, 8'h00);
         rd(12'h00c, 2'b00, st);
         rd(12'h014, 2'b00, trim);
      end
   endtask
   // result watcher: oldest note against each read answer
   always @(posedge aclk)
      if (rvalid === 1'b1 && rready === 1'b1)
         check({rresp, rdata}, expq.pop_front());
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // hang guard, sized well beyond seven reset holds
   initial
   begin
      #300us;
      mismatches++;
      finish_test();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(90));
      {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = 7'h0;
      {awaddr, araddr, wdata, kind, prog_read_last} = '0;
      wstrb = 4'h1;
      cfg_word = (12'($urandom) & 12'hfe3) | 12'h014;
      cal_word = 8'($urandom);
      trim = 8'($urandom);
      k_tab = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h4, 3'h5};
      st_tab = '{8'h18, 8'h08, 8'h10, 8'h00, 8'h90, 8'h50};
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h028, 2'b00, 8'h14);
      rd(12'h00c, 2'b00, 8'h18);
      rd(12'h014, 2'b00, 8'hfe);
      rd(12'h040, 2'b10, 8'h00);
      check(core_reset_n, 1'b0);
      check({code_protect, watchdog_enable, reset_pin_select}, 3'h7);
      check(prog_read_allow, 1'b0);
      prog_read_last <= 1'b1;
      @(posedge aclk);
      @(posedge aclk);
      check(prog_read_allow, 1'b1);
      wait_core(1'b1);
      check(working_value, cal_word);
      rd(12'h028, 2'b10, 8'h00);
      wr(12'h028, 8'h00, 2'b10);
      wr(12'h014, trim, 2'b00);
      rd(12'h014, 2'b00, trim);
      for (int i = 0; i < 6; i++)
      begin
         if (k_tab[i] == 3'h4)
            wr(12'h020, 8'h7f, 2'b00);
         if (k_tab[i] == 3'h5)
            wr(12'h01c, 8'hfe, 2'b00);
         fire(k_tab[i], 1'b1, st_tab[i]);
      end
      cfg_word <= cfg_word & 12'hfeb;
      @(posedge aclk);
      fire(3'h0, 1'b0, 8'h00);
      fire(3'h2, 1'b0, 8'h00);
      repeat (4) @(posedge aclk);
      finish_test();
   end
endmodule
